/* src/sarseq_cfg.svh */
// register offsets, field positions, reset values and timing for the
// successive-approximation sequencer; included by package and design
`ifndef SARSEQ_CFG_SVH
`define SARSEQ_CFG_SVH
`define SARSEQ_ADDR_W     4
`define SARSEQ_DATA_W     16
`define SARSEQ_OFS_MODE   4'h0
`define SARSEQ_OFS_CHAN   4'h1
`define SARSEQ_OFS_PCFG   4'h2
`define SARSEQ_OFS_PDIR   4'h3
`define SARSEQ_OFS_RESF   4'h4
`define SARSEQ_OFS_RESU   4'h5
`define SARSEQ_OFS_IRQF   4'h6
`define SARSEQ_RUN_BIT    7
`define SARSEQ_TIME_HI    5
`define SARSEQ_TIME_LO    1
`define SARSEQ_CMPEN_BIT  0
`define SARSEQ_CHAN_HI    2
`define SARSEQ_PCFG_HI    3
`define SARSEQ_IRQF_BIT   0
`define SARSEQ_MODE_RST   8'h00
`define SARSEQ_CHAN_RST   3'h0
`define SARSEQ_PCFG_RST   4'h0
`define SARSEQ_PDIR_RST   8'hFF
`define SARSEQ_RESF_RST   16'h0000
`define SARSEQ_RESU_RST   8'h00
`define SARSEQ_LJ_SHIFT   6
`define SARSEQ_CLK_NS     50
`endif

/* src/sarseq_pkg.sv */
// types shared by the sequencer and its bench
// assumes sarseq_cfg.svh sits on the include path
`include "sarseq_cfg.svh"
package sarseq_pkg;
   typedef struct packed {
      logic [`SARSEQ_ADDR_W-1:0] addr;
      logic [`SARSEQ_DATA_W-1:0] wdata;
      logic                      wr;
      logic                      rd;
   } sarseq_bus_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_SAMPLE  = 3'b010,
      ST_CONVERT = 3'b100
   } sarseq_state_t;
endpackage

/* src/sarseq_top.sv */
// sequencer for an 8-input successive-approximation converter
// assumes an analog front end that samples the selected input while
// sampleOn is high and reports cmpHigh for the trial code on dacCode
`timescale 1ns/10ps
`default_nettype none
`include "sarseq_cfg.svh"

// Notes on behaviour
// - setting run starts converting the input named by channel select.
// - conversions repeat back to back while run stays set.
// - each end without a control write or stop mode stores the result, pulses the interrupt, restarts.
// - channel-select write mid-conversion abandons it; restarts if running.
// - clearing run stops at once; previous result stays.
// - a 16-bit and an 8-bit result register exist.
// - reset clears both result registers to zero.
// - 16-bit result holds the 10-bit value times 64, left-justified.
// - select mode only; 3-bit channel field picks one of eight inputs.
// - conversion time comes from mode bits 5 to 1.
// - after a channel change, next interrupt comes one conversion time later.
// - the programmed conversion time includes the sampling interval.
// - the converter halts in stop power mode.
// - a result read colliding with result write is served first.
// - a control write at conversion end wins; no result, no interrupt.
// - result bits resolve from 9 down to 0, trial set then decided.
// - channel-select writes leave the interrupt flag alone.
module sarseq_top #(
   parameter int RES_BITS = 10
) (
   input  wire logic                    sys_clk,
   input  wire logic                    resetn,
   input  wire sarseq_pkg::sarseq_bus_t busReq,
   output logic [`SARSEQ_DATA_W-1:0]    rdData,
   input  wire logic                    stopMode,
   input  wire logic                    cmpHigh,
   output logic [RES_BITS-1:0]          dacCode,
   output logic                         sampleOn,
   output logic                         cmpEnable,
   output logic [`SARSEQ_CHAN_HI:0]     chanSel,
   output logic [`SARSEQ_PCFG_HI:0]     portConfig,
   output logic [7:0]                   portDirection,
   output logic                         convDoneIrq,
   output logic                         irqFlag,
   output logic                         busy
);
   localparam int TW = `SARSEQ_TIME_HI - `SARSEQ_TIME_LO + 1;
   localparam logic [3:0] LAST_BIT = 4'(RES_BITS - 1);

   // result layout below is fixed to a 10-bit code in a 16-bit word
   if (RES_BITS != 10) begin : g_bad_res
      $error("sarseq_top: RES_BITS must be 10");
   end

   logic [7:0]                   modeReg;
   logic [`SARSEQ_DATA_W-1:0]    resFull;
   logic [7:0]                   resUpper;
   sarseq_pkg::sarseq_state_t    state;
   sarseq_pkg::sarseq_state_t    next_state;
   logic [TW:0]                  stepCnt;
   logic [TW:0]                  next_stepCnt;
   logic [3:0]                   bitIdx;
   logic [3:0]                   next_bitIdx;
   logic [RES_BITS-1:0]          successive_approx_reg;
   logic [RES_BITS-1:0]          next_sar;

   // register decode
   wire hitMode = busReq.addr == `SARSEQ_OFS_MODE;
   wire hitChan = busReq.addr == `SARSEQ_OFS_CHAN;
   wire hitPcfg = busReq.addr == `SARSEQ_OFS_PCFG;
   wire hitPdir = busReq.addr == `SARSEQ_OFS_PDIR;
   wire hitResF = busReq.addr == `SARSEQ_OFS_RESF;
   wire hitResU = busReq.addr == `SARSEQ_OFS_RESU;
   wire hitIrqF = busReq.addr == `SARSEQ_OFS_IRQF;
   wire wrMode  = busReq.wr && hitMode;
   wire wrChan  = busReq.wr && hitChan;
   wire wrPcfg  = busReq.wr && hitPcfg;
   wire wrPdir  = busReq.wr && hitPdir;
   wire wrIrqF  = busReq.wr && hitIrqF;

   // run as it stands after this cycle, so a clearing write acts at once
   wire nextRun = wrMode ? busReq.wdata[`SARSEQ_RUN_BIT]
                         : modeReg[`SARSEQ_RUN_BIT];
   wire abort   = !nextRun || stopMode;
   wire restart = wrChan;
   wire ctrlWr  = wrMode || wrChan || wrPcfg;

   // each phase lasts field+1 cycles: one sample phase plus one per bit,
   // so the whole programmed time covers sampling as well
   wire [TW-1:0] timeSel =
      modeReg[`SARSEQ_TIME_HI:`SARSEQ_TIME_LO];
   wire [TW:0] stepLast = {1'b0, timeSel};
   wire stepEnd  = stepCnt == stepLast;
   wire inConv   = state == sarseq_pkg::ST_CONVERT;
   wire bitEnd   = inConv && stepEnd;
   wire convEnd  = bitEnd && (bitIdx == 4'h0);
   // a control write in the finishing cycle suppresses the commit
   wire commit   = convEnd && !ctrlWr && !stopMode;

   always_comb begin
      next_state = state;
      if (abort) begin
         next_state = sarseq_pkg::ST_IDLE;
      end else if (restart) begin
         next_state = sarseq_pkg::ST_SAMPLE;
      end else begin
         unique case (state)
            sarseq_pkg::ST_IDLE: begin
               next_state = sarseq_pkg::ST_SAMPLE;
            end
            sarseq_pkg::ST_SAMPLE: begin
               if (stepEnd) begin
                  next_state = sarseq_pkg::ST_CONVERT;
               end
            end
            sarseq_pkg::ST_CONVERT: begin
               if (convEnd) begin
                  next_state = sarseq_pkg::ST_SAMPLE;
               end
            end
            default: begin
               next_state = sarseq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   wire phaseChange = next_state != state;
   wire freshStart  = restart && !abort;

   always_comb begin
      if (phaseChange || freshStart || stepEnd) begin
         next_stepCnt = '0;
      end else begin
         next_stepCnt = stepCnt + (TW+1)'(1);
      end
   end

   always_comb begin
      if (next_state != sarseq_pkg::ST_CONVERT) begin
         next_bitIdx = LAST_BIT;
      end else if (bitEnd && !freshStart) begin
         next_bitIdx = bitIdx - 4'h1;
      end else begin
         next_bitIdx = bitIdx;
      end
   end

   // each bit keeps the comparator decision at the end of its own step
   for (genvar g = 0; g < RES_BITS; g++) begin : g_sar
      wire decide = bitEnd && (bitIdx == 4'(g));
      assign next_sar[g] =
         (state == sarseq_pkg::ST_SAMPLE) ? 1'b0 :
         decide ? cmpHigh : successive_approx_reg[g];
   end

   // trial code: decided bits plus the bit under test set tentatively
   wire [RES_BITS-1:0] trialBit =
      (next_state == sarseq_pkg::ST_CONVERT)
         ? (RES_BITS)'(1) << next_bitIdx : '0;
   wire [RES_BITS-1:0] sarKeep =
      (next_state == sarseq_pkg::ST_CONVERT) ? next_sar : '0;
   wire [RES_BITS-1:0] next_dac = sarKeep | trialBit;

   wire [`SARSEQ_DATA_W-1:0] next_resFull =
      {next_sar, `SARSEQ_LJ_SHIFT'(0)};
   wire [7:0] next_resUpper =
      next_sar[RES_BITS-1:RES_BITS-8];

   // the interrupt flag only clears on a write of zero; set wins
   wire next_irqFlag = commit ||
      (irqFlag && !(wrIrqF && !busReq.wdata[`SARSEQ_IRQF_BIT]));

   wire [`SARSEQ_DATA_W-1:0] rdMux =
      hitMode ? {8'h00, modeReg} :
      hitChan ? {13'h0000, chanSel} :
      hitPcfg ? {12'h000, portConfig} :
      hitPdir ? {8'h00, portDirection} :
      hitResF ? resFull :
      hitResU ? {8'h00, resUpper} :
      hitIrqF ? {15'h0000, irqFlag} : '0;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state   <= sarseq_pkg::ST_IDLE;
         stepCnt <= '0;
         bitIdx  <= LAST_BIT;
         successive_approx_reg     <= '0;
         dacCode <= '0;
      end else begin
         state   <= next_state;
         stepCnt <= next_stepCnt;
         bitIdx  <= next_bitIdx;
         successive_approx_reg     <= next_sar;
         dacCode <= next_dac;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         modeReg       <= `SARSEQ_MODE_RST;
         chanSel       <= `SARSEQ_CHAN_RST;
         portConfig    <= `SARSEQ_PCFG_RST;
         portDirection <= `SARSEQ_PDIR_RST;
      end else begin
         if (wrMode) begin
            modeReg <= busReq.wdata[7:0] & 8'hBF;
         end
         if (wrChan) begin
            chanSel <= busReq.wdata[`SARSEQ_CHAN_HI:0];
         end
         if (wrPcfg) begin
            portConfig <= busReq.wdata[`SARSEQ_PCFG_HI:0];
         end
         if (wrPdir) begin
            portDirection <= busReq.wdata[7:0];
         end
      end
   end

   // read data captures the old result at the same edge the new one
   // lands, so a colliding read is served before the update
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         resFull     <= `SARSEQ_RESF_RST;
         resUpper    <= `SARSEQ_RESU_RST;
         convDoneIrq <= 1'b0;
         irqFlag     <= 1'b0;
         rdData      <= '0;
      end else begin
         if (commit) begin
            resFull  <= next_resFull;
            resUpper <= next_resUpper;
         end
         convDoneIrq <= commit;
         irqFlag     <= next_irqFlag;
         rdData      <= busReq.rd ? rdMux : '0;
      end
   end

   assign sampleOn  = state == sarseq_pkg::ST_SAMPLE;
   assign busy      = state != sarseq_pkg::ST_IDLE;
   assign cmpEnable = modeReg[`SARSEQ_CMPEN_BIT];
endmodule
`default_nettype wire

/* verif/sarseq_props.sv */
// port assertions for the conversion sequencer
// assumes the package and cfg header are compiled ahead of this file
`timescale 1ns/10ps
`default_nettype none
`include "sarseq_cfg.svh"
module sarseq_props #(
   parameter int RES_BITS = 10
) (
   input wire logic                    sys_clk,
   input wire logic                    resetn,
   input wire sarseq_pkg::sarseq_bus_t busReq,
   input wire logic [15:0]             rdData,
   input wire logic                    stopMode,
   input wire logic                    cmpHigh,
   input wire logic [RES_BITS-1:0]     dacCode,
   input wire logic                    sampleOn,
   input wire logic                    cmpEnable,
   input wire logic [2:0]              chanSel,
   input wire logic [3:0]              portConfig,
   input wire logic [7:0]              portDirection,
   input wire logic                    convDoneIrq,
   input wire logic                    irqFlag,
   input wire logic                    busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   wire modeWr = busReq.wr && busReq.addr == `SARSEQ_OFS_MODE;
   wire chanWr = busReq.wr && busReq.addr == `SARSEQ_OFS_CHAN;
   wire runBit = busReq.wdata[`SARSEQ_RUN_BIT];
   sequence s_start;
      modeWr && runBit && !stopMode && !busy;
   endsequence
   sequence s_halt;
      (modeWr && !runBit) || stopMode;
   endsequence
   sequence s_restart;
      chanWr && busy && !stopMode;
   endsequence
   a_run_starts: assert property (s_start |=> sampleOn && busy)
      else $error("run set but sampling did not begin");
   a_halt_idle: assert property (s_halt |=> !busy && !convDoneIrq)
      else $error("converter kept running after halt");
   a_chan_restart: assert property (s_restart |=> sampleOn)
      else $error("channel write did not restart sampling");
   a_chan_keeps_flag: assert property (chanWr && irqFlag |=> irqFlag)
      else $error("channel write cleared the flag");
   a_irq_one_pulse: assert property (convDoneIrq |=> !convDoneIrq)
      else $error("end pulse longer than one cycle");
   a_irq_sets_flag: assert property (convDoneIrq |-> irqFlag && sampleOn)
      else $error("end pulse without flag or restart");
   a_idle_code_zero: assert property (!busy |-> dacCode == '0)
      else $error("trial code active while idle");
   a_msb_trial: assert property ($fell(sampleOn) && busy |->
      dacCode == {1'b1, {(RES_BITS-1){1'b0}}})
      else $error("first trial is not the top bit");
endmodule
bind sarseq_top sarseq_props #(.RES_BITS(RES_BITS)) u_props (
   .sys_clk(sys_clk), .resetn(resetn), .busReq(busReq), .rdData(rdData),
   .stopMode(stopMode), .cmpHigh(cmpHigh), .dacCode(dacCode),
   .sampleOn(sampleOn), .cmpEnable(cmpEnable), .chanSel(chanSel),
   .portConfig(portConfig), .portDirection(portDirection),
   .convDoneIrq(convDoneIrq), .irqFlag(irqFlag), .busy(busy));
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the conversion sequencer
// assumes package, cfg header and checker are compiled ahead of it
`timescale 1ns/10ps
`default_nettype none
`include "sarseq_cfg.svh"
module tb_top;
   localparam logic [3:0] MODE = `SARSEQ_OFS_MODE;
   localparam logic [3:0] CHAN = `SARSEQ_OFS_CHAN;
   localparam logic [3:0] RESF = `SARSEQ_OFS_RESF;
   localparam logic [3:0] RESU = `SARSEQ_OFS_RESU;
   logic                    sys_clk = 1'b0;
   logic                    resetn = 1'b0;
   sarseq_pkg::sarseq_bus_t busReq = '0;
   logic                    stopMode = 1'b0;
   logic [9:0]              target = 10'h2B5;
   logic [15:0]             rdData, got;
   logic [9:0]              dacCode;
   logic [3:0]              portConfig;
   logic [7:0]              portDirection;
   logic [2:0]              chanSel;
   logic                    sampleOn, cmpEnable, convDoneIrq, irqFlag, busy;
   int                      mismatches = 0;
   int                      checked = 0;
   int                      n;
   // ideal comparator: input at or above the tap keeps the bit
   wire logic               cmpHigh = dacCode <= target;
   sarseq_top dut (.sys_clk(sys_clk), .resetn(resetn), .busReq(busReq),
      .rdData(rdData), .stopMode(stopMode), .cmpHigh(cmpHigh),
      .dacCode(dacCode), .sampleOn(sampleOn), .cmpEnable(cmpEnable),
      .chanSel(chanSel), .portConfig(portConfig),
      .portDirection(portDirection), .convDoneIrq(convDoneIrq),
      .irqFlag(irqFlag), .busy(busy));
   always #25 sys_clk = ~sys_clk;
   task automatic ck(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      busReq.wr <= 1'b0;
      #1;
   endtask
   task automatic rdck(input logic [3:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      busReq.rd <= 1'b0;
      #1 got = rdData;
      ck(got, e);
   endtask
   task automatic chkRes(input logic [9:0] c);
      rdck(RESF, {c, 6'h00});
      rdck(RESU, {8'h00, c[9:2]});
   endtask
   // counts edges until the end pulse is seen, capped against hangs
   task automatic waitIrq;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (convDoneIrq !== 1'b1 && n < 400);
   endtask
   task automatic end_of_test;
      if (mismatches == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      chkRes(10'h000);
      rdck(`SARSEQ_OFS_PDIR, 16'h00FF);
      rdck(4'hF, 16'h0000);
      wr(MODE, 16'h0041);
      rdck(MODE, 16'h0001);
      ck({15'h0, cmpEnable}, 16'h0001);
      wr(`SARSEQ_OFS_PCFG, 16'h0008);
      ck({12'h0, portConfig}, 16'h0008);
      wr(CHAN, 16'h0005);
      ck({13'h0, chanSel}, 16'h0005);
      // comparator settles at least 1 us before run
      repeat (20) @(posedge sys_clk);
      wr(MODE, 16'h0081);
      waitIrq();
      ck(16'(n), 16'd11);
      chkRes(10'h2B5);
      ck({15'h0, irqFlag}, 16'h0001);
      // four edges of result reads already spent since the pulse
      waitIrq();
      ck(16'(n), 16'd7);
      target <= 10'h3FF;
      repeat (9) @(posedge sys_clk);
      rdck(RESF, {10'h2B5, 6'h00});
      rdck(RESF, 16'hFFC0);
      waitIrq();
      target <= 10'h001;
      repeat (9) @(posedge sys_clk);
      wr(`SARSEQ_OFS_PCFG, 16'h0008);
      ck({15'h0, convDoneIrq}, 16'h0000);
      rdck(RESF, 16'hFFC0);
      wr(MODE, 16'h0001);
      wr(MODE, 16'h0081);
      repeat (4) @(posedge sys_clk);
      wr(MODE, 16'h0001);
      ck({15'h0, busy}, 16'h0000);
      rdck(RESF, 16'hFFC0);
      wr(MODE, 16'h0081);
      repeat (4) @(posedge sys_clk);
      wr(CHAN, 16'h0002);
      ck({15'h0, irqFlag}, 16'h0001);
      waitIrq();
      ck(16'(n), 16'd11);
      chkRes(10'h001);
      // shortest and longest non-trivial phase lengths
      for (int t = 1; t < 32; t += 30) begin
         wr(MODE, 16'h0001);
         wr(MODE, 16'(8'h81 | (t << 1)));
         waitIrq();
         ck(16'(n), 16'(11 * (t + 1)));
      end
      @(posedge sys_clk);
      stopMode <= 1'b1;
      @(posedge sys_clk);
      #1 ck({15'h0, busy}, 16'h0000);
      stopMode <= 1'b0;
      wr(MODE, 16'h0000);
      wr(`SARSEQ_OFS_IRQF, 16'h0000);
      ck({15'h0, irqFlag}, 16'h0000);
      wr(RESF, 16'h1234);
      chkRes(10'h001);
      end_of_test();
   end
endmodule
`default_nettype wire
